// File: src/link_diag_pkg.sv
// Constants for the link timer and PHY diagnostic register pair.
// Assumes a 200 MHz core clock and byte offsets in configuration space.
package link_diag_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFF_LINK_TIMER_CONTROL = 8'hC4;
  localparam logic [7:0] OFF_PHY_LINK_CONTROL = 8'hC8;

  // ****************************************
  // Reset values and writable bits
  // ****************************************
  localparam logic [31:0] RESET_LINK_TIMER_CONTROL = 32'h00120108;
  localparam logic [31:0] RESET_PHY_LINK_CONTROL = 32'h32142000;
  localparam logic [31:0] WRITABLE_LINK_TIMER_CONTROL = 32'h001FFFFF;
  localparam logic [31:0] WRITABLE_PHY_LINK_CONTROL = 32'hFFFF1FFF;
  // Bits cleared by the warm reset as well as the fundamental reset
  localparam logic [31:0] WARM_RESET_BITS = 32'h000000FF;

  // ****************************************
  // Field positions, link timer control register
  // ****************************************
  localparam int L1_SEPARATE_LSB = 18;
  localparam int L1_SHARED_LSB = 15;
  localparam int ADVERTISED_L1_EXIT_LATENCY_WIDTH = 3;
  localparam int SECONDARY_BLOCK_BIT = 10;
  localparam int LOW_POWER_TIMER_LSB = 6;
  localparam int STANDBY_TIMER_LSB = 2;
  localparam int ENTRY_TIMER_WIDTH = 4;

  // ****************************************
  // Field positions, PHY link control register
  // ****************************************
  localparam int FTS_SEPARATE_LSB = 24;
  localparam int FTS_SHARED_LSB = 16;
  localparam int FTS_WIDTH = 8;
  localparam int PHY_REVISION_LSB = 13;
  localparam int PHY_REVISION_WIDTH = 3;
  localparam int LINK_NUMBER_LSB = 8;
  localparam int LINK_NUMBER_WIDTH = 5;
  localparam int DEEP_SLEEP_BIT = 7;
  localparam int SECOND_WINDOW_BIT = 6;
  localparam int FIRST_WINDOW_BIT = 5;
  localparam int RETRAIN_BIT = 4;
  localparam int RECONFIGURE_BIT = 3;
  localparam int LINK_RESET_BIT = 2;
  localparam int SCRAMBLING_OFF_BIT = 1;
  localparam int LOOP_BIT = 0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLOCK_PERIOD_PS = 5000;
  localparam int LOW_POWER_TICK_NS = 512;
  localparam int STANDBY_TICK_KHZ = 62500;
  localparam int LOW_POWER_TICK_PS = LOW_POWER_TICK_NS * 1000;
  localparam int STANDBY_TICK_PS = 1000000000 / STANDBY_TICK_KHZ;

endpackage : link_diag_pkg

// File: src/tick_divider.sv
// Fractional divider giving one-cycle tick enables at an average period.
// Assumes both periods are whole picoseconds and TICK_PS >= CLK_PS.
`timescale 1ns/100ps
module tick_divider #(
  parameter int CLK_PS = 5000,
  parameter int TICK_PS = 16000
) (
  input wire logic clock, // Core clock
  input wire logic reset_n, // Asynchronous reset, active low
  output logic tick // One-cycle pulse per tick period
);

  logic [23:0] phase_r;
  logic [23:0] phaseSum;
  logic wrap;

  // Phase accumulator carries the remainder so the mean period is exact
  assign phaseSum = phase_r + 24'(CLK_PS);
  assign wrap = phaseSum >= 24'(TICK_PS);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= 24'h000000;
      tick <= 1'b0;
    end else begin
      phase_r <= wrap ? phaseSum - 24'(TICK_PS) : phaseSum;
      tick <= wrap;
    end
  end

endmodule : tick_divider

// File: src/entry_timer.sv
// Idle timer that requests a power state once idle for a set tick count.
// Assumes the tick input is a one-cycle enable from a divider.
`timescale 1ns/100ps
module entry_timer #(
  parameter int WIDTH = 4
) (
  input wire logic clock, // Core clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic tick, // Time unit enable
  input wire logic idle, // Link idle level
  input wire logic [WIDTH-1:0] limit, // Ticks of idle before entry
  output logic entryRequest // Entry request level
);

  logic [WIDTH-1:0] count_r;
  logic reached;

  assign reached = count_r >= limit;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= '0;
      entryRequest <= 1'b0;
    end else begin
      // Any activity restarts the idle count
      if (!idle) begin
        count_r <= '0;
      end else if (tick && !reached) begin
        count_r <= count_r + WIDTH'(1);
      end
      entryRequest <= idle && reached;
    end
  end

endmodule : entry_timer

// File: src/link_diag_regs.sv
// Link timer control and PHY link control diagnostic registers.
// Assumes configuration and EEPROM loads arrive synchronous to clock and
// that reset_n is the fundamental reset (low while link or global reset).
`timescale 1ns/100ps

// Contract
// - Shared clock set: separate-clock Advertised_l1_exit_latency is advertised; resets 100b.
// - Shared clock clear: shared-clock Advertised_l1_exit_latency is advertised; resets 100b.
// - While the block bit is set, secondary bus reset requests are ignored.
// - L1 entry timer, bits 9:6, counts 512 ns units, resets 0100b.
// - L0s entry timer, bits 5:2, counts 62.5 MHz periods, resets 0010b.
// - Upper bits of the first register read zero; writes ignored.
// - Marked fields reset only on fundamental reset.
// - Shared clock clear: send fast training count from bits 31:24, reset 32h.
// - Shared clock set: send fast training count from bits 23:16, reset 14h.
// - Deep sleep saving applies in L2 only while its enable bit is set.
// - Second window enabled only while bit 6 set; resets disabled.
// - First window enabled only while bit 5 set; resets disabled.
// - Bits 4 and 3 go out as retrain and reconfigure requests.
// - Bit 2 of the second register goes out as link reset request.
// - Bits 1 and 0 go out as scrambling off and loop requests.
module link_diag_regs
  import link_diag_pkg::*;
#(
  parameter logic [PHY_REVISION_WIDTH-1:0] PHY_REVISION = 3'h1 // Arbitrary value
) (
  input wire logic clock, // 200 MHz core clock
  input wire logic reset_n, // Fundamental reset, active low
  input wire logic warmReset, // Synchronous reset of unmarked bits
  input wire logic cfgValid, // Configuration access strobe
  input wire logic cfgWrite, // Access is a write
  input wire logic [7:0] cfgAddr, // Byte offset of the dword
  input wire logic [3:0] cfgByteEnable, // Byte lanes of a write
  input wire logic [31:0] cfgWriteData, // Write data
  output logic [31:0] cfgReadData, // Read data
  output logic cfgDone, // Access completed pulse
  input wire logic eepromLoad, // EEPROM loader word strobe
  input wire logic [7:0] eepromAddr, // EEPROM loader target offset
  input wire logic [31:0] eepromData, // EEPROM loader word
  input wire logic sharedClockConfig, // Common clock bit of link control
  input wire logic secondaryBusResetBit, // Bridge control reset bit
  input wire logic linkIdle, // Link has nothing to send
  input wire logic linkInL2, // Link is in L2
  output logic [2:0] advertisedL1ExitLatency, // Into link capabilities
  output logic [7:0] fastTrainCount, // Ordered sets on L0s exit
  output logic secondaryBusReset, // Reset to the secondary bus
  output logic lowPowerEntryRequest, // L1 entry request
  output logic standbyEntryRequest, // L0s entry request
  output logic deepSleepSavingActive, // Apply L2 power savings
  output logic firstWindowEnable, // Enable first base address window
  output logic secondWindowEnable, // Enable second base address window
  output logic retrainRequest, // Recovery request to link training
  output logic reconfigureRequest, // Reconfiguration request
  output logic linkResetRequest, // Hot reset request
  output logic scramblingOffRequest, // Scrambler disable request
  output logic loopRequest, // Loopback request
  output logic [4:0] linkNumber // Link number field
);

  // ****************************************
  // Write merge
  // ****************************************
  function automatic logic [31:0] merge_word(
    input logic [31:0] current,
    input logic [31:0] data,
    input logic [3:0] lanes,
    input logic [31:0] writable
  );
    logic [31:0] laneMask;
    laneMask = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
    merge_word = (current & ~(laneMask & writable)) | (data & laneMask & writable);
  endfunction : merge_word

  // ****************************************
  // Storage
  // ****************************************
  logic [31:0] linkTimerControl_r;
  logic [31:0] linkTimerControl_nxt;
  logic [31:0] phyLinkControl_r;
  logic [31:0] phyLinkControl_nxt;
  logic [31:0] phyMerged;

  // ****************************************
  // Access decode
  // ****************************************
  wire cfgWriteAccess = cfgValid && cfgWrite;
  wire cfgReadAccess = cfgValid && !cfgWrite;
  wire eepromAccess = eepromLoad && !cfgValid;
  wire cfgHitTimer = cfgAddr == OFF_LINK_TIMER_CONTROL;
  wire cfgHitPhy = cfgAddr == OFF_PHY_LINK_CONTROL;
  wire eepromHitTimer = eepromAddr == OFF_LINK_TIMER_CONTROL;
  wire eepromHitPhy = eepromAddr == OFF_PHY_LINK_CONTROL;
  wire writeTimerCfg = cfgWriteAccess && cfgHitTimer;
  wire writeTimerEeprom = eepromAccess && eepromHitTimer;
  wire writePhyCfg = cfgWriteAccess && cfgHitPhy;
  wire writePhyEeprom = eepromAccess && eepromHitPhy;

  // ****************************************
  // Next register values
  // ****************************************
  // Reserved read-only bits are outside the writable mask and stay zero
  always_comb begin
    linkTimerControl_nxt = linkTimerControl_r;
    if (writeTimerCfg) begin
      linkTimerControl_nxt = merge_word(linkTimerControl_r, cfgWriteData, cfgByteEnable,
        WRITABLE_LINK_TIMER_CONTROL);
    end else if (writeTimerEeprom) begin
      // Reserved read/write bits are stored as written
      linkTimerControl_nxt = merge_word(linkTimerControl_r, eepromData, 4'hF,
        WRITABLE_LINK_TIMER_CONTROL);
    end
  end

  always_comb begin
    phyMerged = phyLinkControl_r;
    if (writePhyCfg) begin
      phyMerged = merge_word(phyLinkControl_r, cfgWriteData, cfgByteEnable,
        WRITABLE_PHY_LINK_CONTROL);
    end else if (writePhyEeprom) begin
      phyMerged = merge_word(phyLinkControl_r, eepromData, 4'hF, WRITABLE_PHY_LINK_CONTROL);
    end
    // Unmarked bits also fall back on a warm reset; marked ones do not
    phyLinkControl_nxt = phyMerged;
    if (warmReset) begin
      phyLinkControl_nxt = (phyMerged & ~WARM_RESET_BITS) |
        (RESET_PHY_LINK_CONTROL & WARM_RESET_BITS);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      linkTimerControl_r <= RESET_LINK_TIMER_CONTROL;
      phyLinkControl_r <= RESET_PHY_LINK_CONTROL & WRITABLE_PHY_LINK_CONTROL;
    end else begin
      linkTimerControl_r <= linkTimerControl_nxt;
      phyLinkControl_r <= phyLinkControl_nxt;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  wire [31:0] revisionWord = 32'(PHY_REVISION) << PHY_REVISION_LSB;
  wire [31:0] timerReadValue = linkTimerControl_r & WRITABLE_LINK_TIMER_CONTROL;
  wire [31:0] phyReadValue = (phyLinkControl_r & WRITABLE_PHY_LINK_CONTROL) |
    revisionWord;
  wire [31:0] readSelect = cfgHitTimer ? timerReadValue :
    cfgHitPhy ? phyReadValue : 32'h00000000;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfgReadData <= 32'h00000000;
      cfgDone <= 1'b0;
    end else begin
      cfgDone <= cfgValid;
      if (cfgReadAccess) begin
        cfgReadData <= readSelect;
      end
    end
  end

  // ****************************************
  // Field extraction
  // ****************************************
  wire [2:0] l1ExitLatencySeparateClock =
    linkTimerControl_r[L1_SEPARATE_LSB +: ADVERTISED_L1_EXIT_LATENCY_WIDTH];
  wire [2:0] l1ExitLatencySharedClock =
    linkTimerControl_r[L1_SHARED_LSB +: ADVERTISED_L1_EXIT_LATENCY_WIDTH];
  wire secondaryResetBlock = linkTimerControl_r[SECONDARY_BLOCK_BIT];
  wire [3:0] lowPowerEntryTimer =
    linkTimerControl_r[LOW_POWER_TIMER_LSB +: ENTRY_TIMER_WIDTH];
  wire [3:0] standbyEntryTimer =
    linkTimerControl_r[STANDBY_TIMER_LSB +: ENTRY_TIMER_WIDTH];
  wire [7:0] fastTrainCountSeparateClock = phyLinkControl_r[FTS_SEPARATE_LSB +: FTS_WIDTH];
  wire [7:0] fastTrainCountSharedClock = phyLinkControl_r[FTS_SHARED_LSB +: FTS_WIDTH];
  wire [4:0] linkNumberField = phyLinkControl_r[LINK_NUMBER_LSB +: LINK_NUMBER_WIDTH];
  wire deepSleepSavingEnable = phyLinkControl_r[DEEP_SLEEP_BIT];
  wire secondWindowBit = phyLinkControl_r[SECOND_WINDOW_BIT];
  wire firstWindowBit = phyLinkControl_r[FIRST_WINDOW_BIT];
  wire retrainBit = phyLinkControl_r[RETRAIN_BIT];
  wire reconfigureBit = phyLinkControl_r[RECONFIGURE_BIT];
  wire linkResetBit = phyLinkControl_r[LINK_RESET_BIT];
  wire scramblingOffBit = phyLinkControl_r[SCRAMBLING_OFF_BIT];
  wire loopBit = phyLinkControl_r[LOOP_BIT];

  // ****************************************
  // Clock mode selection
  // ****************************************
  wire [2:0] latencySelect = sharedClockConfig ? l1ExitLatencySeparateClock :
    l1ExitLatencySharedClock;
  wire [7:0] fastTrainSelect = sharedClockConfig ? fastTrainCountSharedClock :
    fastTrainCountSeparateClock;
  wire secondaryResetSelect = secondaryBusResetBit && !secondaryResetBlock;
  wire deepSleepSelect = linkInL2 && deepSleepSavingEnable;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      advertisedL1ExitLatency <= RESET_LINK_TIMER_CONTROL[L1_SHARED_LSB +: ADVERTISED_L1_EXIT_LATENCY_WIDTH];
      fastTrainCount <= RESET_PHY_LINK_CONTROL[FTS_SEPARATE_LSB +: FTS_WIDTH];
      secondaryBusReset <= 1'b0;
      deepSleepSavingActive <= 1'b0;
    end else begin
      advertisedL1ExitLatency <= latencySelect;
      fastTrainCount <= fastTrainSelect;
      secondaryBusReset <= secondaryResetSelect;
      deepSleepSavingActive <= deepSleepSelect;
    end
  end

  // ****************************************
  // Window enables and link training requests
  // ****************************************
  // Requests are levels: they last exactly as long as their bits
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      firstWindowEnable <= 1'b0;
      secondWindowEnable <= 1'b0;
      retrainRequest <= 1'b0;
      reconfigureRequest <= 1'b0;
      linkResetRequest <= 1'b0;
      scramblingOffRequest <= 1'b0;
      loopRequest <= 1'b0;
      linkNumber <= RESET_PHY_LINK_CONTROL[LINK_NUMBER_LSB +: LINK_NUMBER_WIDTH];
    end else begin
      firstWindowEnable <= firstWindowBit;
      secondWindowEnable <= secondWindowBit;
      retrainRequest <= retrainBit;
      reconfigureRequest <= reconfigureBit;
      linkResetRequest <= linkResetBit;
      scramblingOffRequest <= scramblingOffBit;
      loopRequest <= loopBit;
      linkNumber <= linkNumberField;
    end
  end

  // ****************************************
  // Entry timers
  // ****************************************
  logic lowPowerTick;
  logic standbyTick;

  // 512 ns units from the 5 ns clock, average period exact
  tick_divider #(
    .CLK_PS(CLOCK_PERIOD_PS),
    .TICK_PS(LOW_POWER_TICK_PS)
  ) lowPowerDivider (
    .clock(clock),
    .reset_n(reset_n),
    .tick(lowPowerTick)
  );

  // 62.5 MHz periods from the 5 ns clock
  tick_divider #(
    .CLK_PS(CLOCK_PERIOD_PS),
    .TICK_PS(STANDBY_TICK_PS)
  ) standbyDivider (
    .clock(clock),
    .reset_n(reset_n),
    .tick(standbyTick)
  );

  entry_timer #(
    .WIDTH(ENTRY_TIMER_WIDTH)
  ) lowPowerTimer (
    .clock(clock),
    .reset_n(reset_n),
    .tick(lowPowerTick),
    .idle(linkIdle),
    .limit(lowPowerEntryTimer),
    .entryRequest(lowPowerEntryRequest)
  );

  entry_timer #(
    .WIDTH(ENTRY_TIMER_WIDTH)
  ) standbyTimer (
    .clock(clock),
    .reset_n(reset_n),
    .tick(standbyTick),
    .idle(linkIdle),
    .limit(standbyEntryTimer),
    .entryRequest(standbyEntryRequest)
  );

endmodule : link_diag_regs

// File: tb/link_diag_regs_checker.sv
// Checker for the link diagnostic register pair, bound to its top module.
// Assumes one clock domain; checks pause while reset_n is low and skip writes made under warmReset.
`timescale 1ns/100ps
module link_diag_regs_checker
  import link_diag_pkg::*;
#(
  parameter logic [2:0] PHY_REVISION = 3'h1 // Arbitrary value
) (
  input wire logic clock, // Clock
  input wire logic reset_n, // Reset
  input wire logic warmReset, // Warm reset
  input wire logic cfgValid, // Strobe
  input wire logic cfgWrite, // Write
  input wire logic [7:0] cfgAddr, // Offset
  input wire logic [3:0] cfgByteEnable, // Lanes
  input wire logic [31:0] cfgWriteData, // Data in
  input wire logic [31:0] cfgReadData, // Data out
  input wire logic sharedClockConfig, // Shared clock
  input wire logic secondaryBusResetBit, // Bus reset bit
  input wire logic linkIdle, // Idle
  input wire logic linkInL2, // In L2
  input wire logic [2:0] advertisedL1ExitLatency, // Latency
  input wire logic [7:0] fastTrainCount, // Training count
  input wire logic secondaryBusReset, // Bus reset
  input wire logic lowPowerEntryRequest, // L1 entry
  input wire logic standbyEntryRequest, // L0s entry
  input wire logic deepSleepSavingActive, // L2 saving
  input wire logic firstWindowEnable, // Window 0
  input wire logic secondWindowEnable, // Window 1
  input wire logic retrainRequest, // Retrain
  input wire logic reconfigureRequest, // Reconfigure
  input wire logic linkResetRequest, // Link reset
  input wire logic scramblingOffRequest, // Scrambler off
  input wire logic loopRequest, // Loop
  input wire logic [4:0] linkNumber // Link number
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  logic wrReq;
  logic timerWrite;
  logic phyWrite;
  logic readTimer;
  logic readPhy;
  assign wrReq = cfgValid && cfgWrite && !warmReset;
  assign timerWrite = wrReq && cfgAddr == OFF_LINK_TIMER_CONTROL;
  assign phyWrite = wrReq && cfgAddr == OFF_PHY_LINK_CONTROL;
  assign readTimer = cfgValid && !cfgWrite && cfgAddr == OFF_LINK_TIMER_CONTROL;
  assign readPhy = cfgValid && !cfgWrite && cfgAddr == OFF_PHY_LINK_CONTROL;
  property p_lat;
    timerWrite && cfgByteEnable[2:1] == 2'h3 |-> ##2 advertisedL1ExitLatency ==
      ($past(sharedClockConfig) ? $past(cfgWriteData[20:18], 2) : $past(cfgWriteData[17:15], 2));
  endproperty
  a_lat: assert property (p_lat) else $error("latency field select wrong");
  property p_fts;
    phyWrite && cfgByteEnable[3:2] == 2'h3 |-> ##2 fastTrainCount ==
      ($past(sharedClockConfig) ? $past(cfgWriteData[23:16], 2) : $past(cfgWriteData[31:24], 2));
  endproperty
  a_fts: assert property (p_fts) else $error("training count select wrong");
  property p_req;
    phyWrite && cfgByteEnable[0] |-> ##2 {secondWindowEnable, firstWindowEnable, retrainRequest,
      reconfigureRequest, linkResetRequest, scramblingOffRequest, loopRequest}
      == $past(cfgWriteData[6:0], 2);
  endproperty
  a_req: assert property (p_req) else $error("request outputs wrong");
  property p_linknum;
    phyWrite && cfgByteEnable[1] |-> ##2 linkNumber == $past(cfgWriteData[12:8], 2);
  endproperty
  a_linknum: assert property (p_linknum) else $error("link number wrong");
  property p_rev;
    readPhy |=> cfgReadData[15:13] == PHY_REVISION;
  endproperty
  a_rev: assert property (p_rev) else $error("revision field wrong");
  property p_rdtimer;
    readTimer |=> cfgReadData[31:21] == 11'h000;
  endproperty
  a_rdtimer: assert property (p_rdtimer) else $error("upper bits not zero");
  property p_sbr;
    !secondaryBusResetBit |=> !secondaryBusReset;
  endproperty
  a_sbr: assert property (p_sbr) else $error("bus reset without request");
  property p_sleep;
    !linkInL2 |=> !deepSleepSavingActive;
  endproperty
  a_sleep: assert property (p_sleep) else $error("saving outside L2");
  property p_idle;
    !linkIdle |=> !standbyEntryRequest && !lowPowerEntryRequest;
  endproperty
  a_idle: assert property (p_idle) else $error("entry while busy");
  cov_phy: cover property (phyWrite);
  cov_shared: cover property ($rose(sharedClockConfig));
  cov_standby: cover property ($rose(standbyEntryRequest));
  cov_low: cover property ($rose(lowPowerEntryRequest));
endmodule : link_diag_regs_checker

bind link_diag_regs link_diag_regs_checker #(.PHY_REVISION(PHY_REVISION)) u_chk (
  .clock(clock), .reset_n(reset_n), .warmReset(warmReset), .cfgValid(cfgValid),
  .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgByteEnable(cfgByteEnable),
  .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
  .sharedClockConfig(sharedClockConfig), .secondaryBusResetBit(secondaryBusResetBit),
  .linkIdle(linkIdle), .linkInL2(linkInL2), .advertisedL1ExitLatency(advertisedL1ExitLatency),
  .fastTrainCount(fastTrainCount), .secondaryBusReset(secondaryBusReset),
  .lowPowerEntryRequest(lowPowerEntryRequest), .standbyEntryRequest(standbyEntryRequest),
  .deepSleepSavingActive(deepSleepSavingActive), .firstWindowEnable(firstWindowEnable),
  .secondWindowEnable(secondWindowEnable), .retrainRequest(retrainRequest),
  .reconfigureRequest(reconfigureRequest), .linkResetRequest(linkResetRequest),
  .scramblingOffRequest(scramblingOffRequest), .loopRequest(loopRequest),
  .linkNumber(linkNumber));

// File: tb/config_requester.sv
// Upstream requester model: configuration accesses and EEPROM word loads.
// Assumes one-cycle strobes and a completion pulse on the following cycle.
`timescale 1ns/100ps
module config_requester
  import link_diag_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic [31:0] cfgReadData, // Read data
  input wire logic cfgDone, // Completion
  output logic cfgValid, // Strobe
  output logic cfgWrite, // Write
  output logic [7:0] cfgAddr, // Offset
  output logic [3:0] cfgByteEnable, // Lanes
  output logic [31:0] cfgWriteData, // Write data
  output logic eepromLoad, // Load strobe
  output logic [7:0] eepromAddr, // Load offset
  output logic [31:0] eepromData, // Load word
  output logic timedOut // No completion
);
  initial begin
    {cfgValid, cfgWrite, eepromLoad, timedOut} = 4'h0;
    {cfgAddr, eepromAddr, cfgByteEnable} = 20'h0;
    {cfgWriteData, eepromData} = 64'h0;
  end
  function automatic logic [31:0] clean(input logic [7:0] a, input logic [31:0] d);
    clean = (a == OFF_LINK_TIMER_CONTROL) ? (d & 32'hFFFF87FC) : d;
  endfunction : clean
  task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clock);
    {cfgValid, cfgWrite, cfgAddr, cfgByteEnable} <= {1'b1, wr, a, be};
    cfgWriteData <= clean(a, d);
    @(posedge clock);
    // Released lines show a changed value so stale data is never mistaken
    {cfgValid, cfgAddr, cfgWriteData} <= {1'b0, ~a, ~d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (cfgDone !== 1'b1 && n < 4);
    q = cfgReadData;
    if (cfgDone !== 1'b1) timedOut = 1'b1;
  endtask : access
  task automatic load(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {eepromLoad, eepromAddr, eepromData} <= {1'b1, a, clean(a, d)};
    @(posedge clock);
    {eepromLoad, eepromAddr, eepromData} <= {1'b0, ~a, ~d};
  endtask : load
endmodule : config_requester

// File: tb/pcie_link_diag_control_regs_bench.sv
// Self-checking bench for the link diagnostic register pair.
// Assumes the requester model drives the configuration and EEPROM ports.
`timescale 1ns/100ps
module pcie_link_diag_control_regs_bench;
  import link_diag_pkg::*;
  localparam logic [2:0] REV = 3'h5; // Arbitrary value
  logic clock, reset_n, warmReset, sharedClockConfig, secondaryBusResetBit, linkIdle, linkInL2;
  logic cfgValid, cfgWrite, cfgDone, eepromLoad, timedOut;
  logic [7:0] cfgAddr, eepromAddr, fastTrainCount;
  logic [3:0] cfgByteEnable;
  logic [31:0] cfgWriteData, cfgReadData, eepromData;
  logic [2:0] advertisedL1ExitLatency;
  logic [4:0] linkNumber;
  logic secondaryBusReset, lowPowerEntryRequest, standbyEntryRequest, deepSleepSavingActive;
  logic firstWindowEnable, secondWindowEnable, retrainRequest, reconfigureRequest;
  logic linkResetRequest, scramblingOffRequest, loopRequest;
  int error_cnt, num_checks;
  link_diag_regs #(.PHY_REVISION(REV)) u_dut (.*);
  config_requester u_host (.clock(clock), .cfgReadData(cfgReadData), .cfgDone(cfgDone),
    .cfgValid(cfgValid), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgByteEnable(cfgByteEnable),
    .cfgWriteData(cfgWriteData), .eepromLoad(eepromLoad), .eepromAddr(eepromAddr),
    .eepromData(eepromData), .timedOut(timedOut));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] q;
    u_host.access(1'b1, a, be, d, q);
    if (timedOut) begin
      error_cnt++;
      conclude();
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    u_host.access(1'b0, a, 4'h0, 32'h0, q);
    if (timedOut) begin
      error_cnt++;
      conclude();
    end
    check(q, exp);
  endtask : rd
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask : settle
  task automatic outs(input logic [31:0] exp);
    check(32'({secondaryBusReset, deepSleepSavingActive, secondWindowEnable, firstWindowEnable,
      retrainRequest, reconfigureRequest, linkResetRequest, scramblingOffRequest, loopRequest,
      linkNumber, advertisedL1ExitLatency, fastTrainCount}), exp);
  endtask : outs
  task automatic timeReq(input logic low, input int lo, input int hi);
    int n;
    n = 0;
    @(posedge clock);
    linkIdle <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while ((low ? lowPowerEntryRequest : standbyEntryRequest) !== 1'b1 && n < hi + 5);
    if (n >= hi + 5) begin
      error_cnt++;
      conclude();
    end
    check(32'(n >= lo && n <= hi), 32'h1);
    @(posedge clock);
    linkIdle <= 1'b0;
    settle();
  endtask : timeReq
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    {reset_n, warmReset, sharedClockConfig, secondaryBusResetBit, linkIdle, linkInL2} = 6'h0;
    error_cnt = 0;
    num_checks = 0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      rd(OFF_LINK_TIMER_CONTROL, 32'h00120108);
      rd(OFF_PHY_LINK_CONTROL, {16'h3214, REV, 13'h0000});
      outs({9'h000, 5'h00, 3'h4, 8'h32});
      $display("reset values test done");
      if (k == 0) begin
        wr(OFF_LINK_TIMER_CONTROL, 4'hF, 32'h00198000);
        wr(OFF_PHY_LINK_CONTROL, 4'hF, 32'hA55A0000);
        settle();
        outs({9'h000, 5'h00, 3'h3, 8'hA5});
        @(posedge clock);
        sharedClockConfig <= 1'b1;
        settle();
        outs({9'h000, 5'h00, 3'h6, 8'h5A});
        $display("clock select test done");
        wr(OFF_LINK_TIMER_CONTROL, 4'hF, 32'hFFFFFFFF);
        rd(OFF_LINK_TIMER_CONTROL, 32'h001F87FC);
        wr(OFF_PHY_LINK_CONTROL, 4'hF, 32'hFFFFFFFF);
        rd(OFF_PHY_LINK_CONTROL, {16'hFFFF, REV, 13'h1FFF});
        rd(8'hCC, 32'h0);
        @(posedge clock);
        {secondaryBusResetBit, linkInL2} <= 2'h3;
        settle();
        outs({9'h0FF, 5'h1F, 3'h7, 8'hFF});
        wr(OFF_PHY_LINK_CONTROL, 4'h1, 32'h0);
        wr(OFF_LINK_TIMER_CONTROL, 4'h2, 32'h0);
        settle();
        outs({9'h100, 5'h1F, 3'h7, 8'hFF});
        $display("access and request test done");
        wr(OFF_PHY_LINK_CONTROL, 4'h1, 32'h000000FF);
        @(posedge clock);
        warmReset <= 1'b1;
        @(posedge clock);
        warmReset <= 1'b0;
        rd(OFF_PHY_LINK_CONTROL, {16'hFFFF, REV, 13'h1F00});
        u_host.load(OFF_PHY_LINK_CONTROL, 32'h0B0C0D0E);
        rd(OFF_PHY_LINK_CONTROL, {16'h0B0C, REV, 13'h0D0E});
        wr(OFF_LINK_TIMER_CONTROL, 4'hF, 32'h0000008C);
        timeReq(1'b0, 7, 20);
        timeReq(1'b1, 103, 313);
        $display("warm reset and timer test done");
        @(posedge clock);
        {reset_n, sharedClockConfig, secondaryBusResetBit, linkInL2} <= 4'h0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
      end
    end
    conclude();
  end
endmodule : pcie_link_diag_control_regs_bench
